// File: logic/filter_nco_map.vh
`ifndef FILTER_NCO_MAP_VH
`define FILTER_NCO_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_FREQ_HOLD 8'h0c
`define OFS_PHASE_HOLD 8'h10
`define OFS_FREQ_STROBE 8'h14
`define OFS_PHASE_STROBE 8'h18
`define OFS_HB_FIR_CONFIG 8'h1c
`define OFS_ACTIVE_FREQ 8'h20
`define OFS_ACTIVE_PHASE 8'h24
`define OFS_STATUS 8'h28

// ----------------------------------------------------------------
// Field positions of the halfband and FIR configuration word
// ----------------------------------------------------------------
`define CFG_EXT_SYNC_BIT 21
`define CFG_HB_BYPASS_BIT 20
`define CFG_HB_EN_MSB 19
`define CFG_HB_EN_LSB 15
`define CFG_DECIM_MSB 14
`define CFG_DECIM_LSB 11
`define CFG_DUAL_REAL_BIT 10
`define CFG_ASYM_BIT 8
`define CFG_TAPS_MSB 7
`define CFG_TAPS_LSB 0

// Writable bits; 31:22 and 9 are reserved and read as zero
`define CFG_WRITE_MASK 32'h003f_fdff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET 32'h0010_0001
`define FREQ_RESET 32'h0000_0000
`define PHASE_RESET 10'h000

// ----------------------------------------------------------------
// Field widths and special codes
// ----------------------------------------------------------------
`define PHASE_WIDTH 10
`define DECIM_CODE_FULL 4'h0
`define DECIM_FULL 5'h10
`define TAPS_INVALID 8'h00

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define STAT_FREQ_PEND_BIT 0
`define STAT_PHASE_PEND_BIT 1
`define STAT_TAPS_BAD_BIT 2
`define STAT_NO_HB_BIT 3

`endif

// File: logic/nco_word_transfer.v
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Holding-to-active transfer, applied on a qualified sample tick
// ----------------------------------------------------------------
module nco_word_transfer #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] holding_value,
  input wire strobe,
  input wire sample_tick,
  output reg [WIDTH-1:0] active_q,
  output reg pending_q
);

  // A strobe only arms the transfer; the copy waits for the sample tick
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= RESET_VALUE;
      pending_q <= 1'b0;
    end else begin
      if (pending_q && sample_tick) begin
        active_q <= holding_value;
      end
      // Set wins over the clear so a strobe in the apply cycle is kept
      if (strobe) begin
        pending_q <= 1'b1;
      end else if (sample_tick) begin
        pending_q <= 1'b0;
      end
    end
  end

endmodule // nco_word_transfer

// File: logic/filter_config_and_nco_strobes.v
// Behaviour
// - Frequency strobe write copies frequency holding word to active word; data ignored.
// - Phase strobe write loads active phase offset from phase holding register.
// - Both carrier transfers happen on the input sample clock.
// - Halfband/FIR configuration is captured and applied on the processing clock.
// - Config bit 21 clear: filter sync input has no filter effect.
// - Bit 21 set: filter sync resets halfband, FIR, resampler, discriminator sequencing.
// - Bit 20 set bypasses all halfbands; clear uses per-stage enables.
// - Bits 19..15 enable halfband stages five down to one.
// - Bits 14..11 set FIR decimation 1..16; code zero means sixteen.
// - Bit 10: zero single complex FIR, one dual real FIRs.
// - Bit 8: zero symmetric coefficients, one asymmetric.
// - Bits 7..0 give FIR taps 1..255; zero is invalid.
// - Oscillator words change only when input sample enable is asserted.
// - Phase holding register is ten bits, bits 9..0, bit 9 MSB.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "filter_nco_map.vh"

module filter_config_and_nco_strobes (
  input wire sys_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Sample side
  input wire input_sample_clock,
  input wire input_sample_enable,
  input wire filter_sync_input,
  // Carrier oscillator words
  output reg [31:0] active_freq_q,
  output reg [`PHASE_WIDTH-1:0] active_phase_q,
  // Filter configuration
  output reg filter_ctrl_reset_q,
  output reg halfband_bypass_q,
  output reg [4:0] halfband_stage_en_q,
  output reg [4:0] fir_decimation_q,
  output reg fir_dual_real_q,
  output reg fir_asymmetric_q,
  output reg [7:0] fir_taps_q
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function [4:0] decim_of;
    input [3:0] code;
    begin
      if (code == `DECIM_CODE_FULL) begin
        decim_of = `DECIM_FULL;
      end else begin
        decim_of = {1'b0, code};
      end
    end
  endfunction

  function [4:0] stages_of;
    input [31:0] cfg;
    begin
      if (cfg[`CFG_HB_BYPASS_BIT]) begin
        stages_of = 5'h00;
      end else begin
        stages_of = cfg[`CFG_HB_EN_MSB:`CFG_HB_EN_LSB];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire addr_phase;

  assign addr_phase = hsel && hready && htrans[1];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // Zero wait states, always OKAY
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data phase write decode
  // ----------------------------------------------------------------
  wire wr_freq_hold;
  wire wr_phase_hold;
  wire wr_freq_strobe;
  wire wr_phase_strobe;
  wire wr_config;

  assign wr_freq_hold = wr_pend_q && (wr_addr_q == `OFS_FREQ_HOLD);
  assign wr_phase_hold = wr_pend_q && (wr_addr_q == `OFS_PHASE_HOLD);
  assign wr_freq_strobe = wr_pend_q && (wr_addr_q == `OFS_FREQ_STROBE);
  assign wr_phase_strobe = wr_pend_q && (wr_addr_q == `OFS_PHASE_STROBE);
  assign wr_config = wr_pend_q && (wr_addr_q == `OFS_HB_FIR_CONFIG);

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  reg [31:0] freq_hold_q;
  reg [`PHASE_WIDTH-1:0] phase_hold_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_hold_q <= `FREQ_RESET;
      phase_hold_q <= `PHASE_RESET;
    end else begin
      if (wr_freq_hold) begin
        freq_hold_q <= hwdata;
      end
      if (wr_phase_hold) begin
        phase_hold_q <= hwdata[`PHASE_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input sample tick
  // ----------------------------------------------------------------
  // The sample clock arrives as a synchronous level; its rising edge,
  // qualified by the sample enable, is the only moment the oscillator
  // words may move, so they stay aligned with the sample stream.
  reg sample_clk_prev_q;
  wire sample_tick;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_clk_prev_q <= 1'b0;
    end else begin
      sample_clk_prev_q <= input_sample_clock;
    end
  end

  assign sample_tick = input_sample_clock && !sample_clk_prev_q && input_sample_enable;

  // ----------------------------------------------------------------
  // Carrier word transfers
  // ----------------------------------------------------------------
  wire [31:0] freq_active;
  wire [`PHASE_WIDTH-1:0] phase_active;
  wire freq_pending;
  wire phase_pending;

  // Strobe data is ignored; only the address matters
  nco_word_transfer #(
    .WIDTH(32),
    .RESET_VALUE(`FREQ_RESET)
  ) u_freq_xfer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .holding_value(freq_hold_q),
    .strobe(wr_freq_strobe),
    .sample_tick(sample_tick),
    .active_q(freq_active),
    .pending_q(freq_pending)
  );

  nco_word_transfer #(
    .WIDTH(`PHASE_WIDTH),
    .RESET_VALUE(`PHASE_RESET)
  ) u_phase_xfer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .holding_value(phase_hold_q),
    .strobe(wr_phase_strobe),
    .sample_tick(sample_tick),
    .active_q(phase_active),
    .pending_q(phase_pending)
  );

  // Output copies so every top output leaves a flip-flop here
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_freq_q <= `FREQ_RESET;
      active_phase_q <= `PHASE_RESET;
    end else begin
      active_freq_q <= freq_active;
      active_phase_q <= phase_active;
    end
  end

  // ----------------------------------------------------------------
  // Halfband and FIR configuration
  // ----------------------------------------------------------------
  reg [31:0] cfg_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CFG_RESET;
    end else if (wr_config) begin
      cfg_q <= hwdata & `CFG_WRITE_MASK;
    end
  end

  // Decoded fields, applied on the processing clock
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfband_bypass_q <= 1'b1;
      halfband_stage_en_q <= 5'h00;
      fir_decimation_q <= `DECIM_FULL;
      fir_dual_real_q <= 1'b0;
      fir_asymmetric_q <= 1'b0;
      fir_taps_q <= 8'h01;
    end else begin
      halfband_bypass_q <= cfg_q[`CFG_HB_BYPASS_BIT];
      halfband_stage_en_q <= stages_of(cfg_q);
      fir_decimation_q <= decim_of(cfg_q[`CFG_DECIM_MSB:`CFG_DECIM_LSB]);
      fir_dual_real_q <= cfg_q[`CFG_DUAL_REAL_BIT];
      fir_asymmetric_q <= cfg_q[`CFG_ASYM_BIT];
      fir_taps_q <= cfg_q[`CFG_TAPS_MSB:`CFG_TAPS_LSB];
    end
  end

  // ----------------------------------------------------------------
  // External filter sync
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_ctrl_reset_q <= 1'b0;
    end else begin
      // Gated by bit 21; with it clear the pin is ignored
      filter_ctrl_reset_q <= filter_sync_input && cfg_q[`CFG_EXT_SYNC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status and read back
  // ----------------------------------------------------------------
  // Programming errors are only flagged, never corrected, so software
  // sees exactly what it wrote.
  wire taps_bad;
  wire no_stage;
  wire [31:0] status_word;
  reg [31:0] rd_d;

  assign taps_bad = (cfg_q[`CFG_TAPS_MSB:`CFG_TAPS_LSB] == `TAPS_INVALID);
  assign no_stage = !cfg_q[`CFG_HB_BYPASS_BIT] && (stages_of(cfg_q) == 5'h00);
  assign status_word = {28'h0000000, no_stage, taps_bad, phase_pending, freq_pending};

  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr)
      `OFS_FREQ_HOLD: begin
        rd_d = freq_hold_q;
      end
      `OFS_PHASE_HOLD: begin
        rd_d = {{(32-`PHASE_WIDTH){1'b0}}, phase_hold_q};
      end
      `OFS_HB_FIR_CONFIG: begin
        rd_d = cfg_q;
      end
      `OFS_ACTIVE_FREQ: begin
        rd_d = freq_active;
      end
      `OFS_ACTIVE_PHASE: begin
        rd_d = {{(32-`PHASE_WIDTH){1'b0}}, phase_active};
      end
      `OFS_STATUS: begin
        rd_d = status_word;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is sampled in the address phase and held through the data phase
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_d;
    end
  end

endmodule // filter_config_and_nco_strobes

// File: tb/strobe_config_props.sv
`timescale 1ns/100ps
`include "filter_nco_map.vh"

module strobe_config_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic input_sample_clock,
  input wire logic input_sample_enable,
  input wire logic filter_sync_input,
  input wire logic [31:0] active_freq_q,
  input wire logic [`PHASE_WIDTH-1:0] active_phase_q,
  input wire logic filter_ctrl_reset_q,
  input wire logic halfband_bypass_q,
  input wire logic [4:0] halfband_stage_en_q,
  input wire logic [4:0] fir_decimation_q
);
  // ----------------------------------------------------------------
  // Tick history; the active words lag a tick by up to three edges
  // ----------------------------------------------------------------
  logic clk_prev_q, t1_q, t2_q, t3_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {clk_prev_q, t1_q, t2_q, t3_q} <= 4'h0;
    end else begin
      clk_prev_q <= input_sample_clock;
      {t1_q, t2_q, t3_q} <= {input_sample_clock && !clk_prev_q && input_sample_enable, t1_q, t2_q};
    end
  end
  sequence recent_tick;
    t1_q || t2_q || t3_q;
  endsequence
  a_freq_on_tick: assert property ($changed(active_freq_q) |-> recent_tick)
    else $error("frequency word moved without a sample tick");
  a_phase_on_tick: assert property ($changed(active_phase_q) |-> recent_tick)
    else $error("phase word moved without a sample tick");
  a_freq_whole: assert property ($changed(active_freq_q) |=> $stable(active_freq_q))
    else $error("frequency word updated in pieces");
  a_phase_whole: assert property ($changed(active_phase_q) |=> $stable(active_phase_q))
    else $error("phase word updated in pieces");
  a_sync_gated: assert property (filter_ctrl_reset_q |-> $past(filter_sync_input))
    else $error("filter reset without sync input");
  a_bypass_stages: assert property (halfband_bypass_q |-> halfband_stage_en_q == 5'h00)
    else $error("stage enabled while bypassed");
  a_decim_range: assert property (fir_decimation_q inside {[5'h01:5'h10]})
    else $error("decimation out of range");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule // strobe_config_props

bind filter_config_and_nco_strobes strobe_config_props props (.sys_clk, .rst_n, .hreadyout, .hresp,
  .input_sample_clock, .input_sample_enable, .filter_sync_input, .active_freq_q, .active_phase_q,
  .filter_ctrl_reset_q, .halfband_bypass_q, .halfband_stage_en_q, .fir_decimation_q);

// File: tb/host_model.sv
`timescale 1ns/100ps
`include "filter_nco_map.vh"

module host_model (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------------------------------
  // Single word transfers; caller enters just after a rising edge
  // ----------------------------------------------------------------
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = 44'h0;
    hsize = 3'b010;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    begin
      if (w && a == `OFS_HB_FIR_CONFIG && (d[7:0] == 8'h00 || (!d[20] && d[19:15] == 5'h00))) begin
        // Invalid words never reach the bus
        $display("host refuses to write an invalid filter config");
        r = 32'h0000_0000;
      end else begin
        {hsel, haddr, htrans, hwrite, hwdata} <= {1'b1, a, 2'b10, w, ~hwdata};
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        {hsel, htrans} <= 3'b000;
        hwdata <= w ? d : ~hwdata;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        r = hrdata;
      end
    end
  endtask
endmodule // host_model

// File: tb/filter_config_and_nco_strobes_tb.sv
`timescale 1ns/100ps
`include "filter_nco_map.vh"

module filter_config_and_nco_strobes_tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic sys_clk = 0, rst_n = 0, input_sample_clock = 0, input_sample_enable = 0, filter_sync_input = 0;
  logic hsel, hwrite, hready, hresp, filter_ctrl_reset_q, halfband_bypass_q, fir_dual_real_q, fir_asymmetric_q;
  logic [7:0] haddr, fir_taps_q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, active_freq_q;
  logic [9:0] active_phase_q;
  logic [4:0] halfband_stage_en_q, fir_decimation_q;
  int fails = 0, total_checks = 0;
  always #10 sys_clk = ~sys_clk;
  filter_config_and_nco_strobes dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .input_sample_clock, .input_sample_enable, .filter_sync_input,
    .active_freq_q, .active_phase_q, .filter_ctrl_reset_q, .halfband_bypass_q, .halfband_stage_en_q,
    .fir_decimation_q, .fir_dual_real_q, .fir_asymmetric_q, .fir_taps_q);
  host_model host (.sys_clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp) begin
        fails++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    begin
      host.xfer(1'b0, a, 32'h0, r);
      chk(nm, r, exp);
    end
  endtask
  // One rising edge of the sample clock, then let the transfer settle
  task automatic tick(input logic en);
    begin
      input_sample_clock <= 1'b1;
      input_sample_enable <= en;
      repeat (2) @(posedge sys_clk);
      // Enable drops with the clock so a following tick never drives it twice at once
      input_sample_clock <= 1'b0;
      input_sample_enable <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic t_reset;
    begin
      rd(`OFS_HB_FIR_CONFIG, `CFG_RESET, "cfg reset");
      chk("fields reset", {halfband_bypass_q, fir_decimation_q, fir_taps_q}, {1'b1, `DECIM_FULL, 8'h01});
      rd(`OFS_FREQ_STROBE, 32'h0, "strobe read");
      $display("test reset done");
    end
  endtask
  task automatic t_freq;
    begin
      wr(`OFS_FREQ_HOLD, 32'h1234_5678);
      wr(`OFS_FREQ_STROBE, 32'hdead_beef);
      repeat (4) @(posedge sys_clk);
      chk("freq before tick", active_freq_q, 32'h0);
      rd(`OFS_STATUS, 32'h0000_0001, "freq pending");
      tick(1'b0);
      chk("freq disabled tick", active_freq_q, 32'h0);
      tick(1'b1);
      chk("freq after tick", active_freq_q, 32'h1234_5678);
      rd(`OFS_STATUS, 32'h0000_0000, "freq pending cleared");
      wr(`OFS_FREQ_HOLD, 32'h8765_4321);
      tick(1'b1);
      rd(`OFS_ACTIVE_FREQ, 32'h1234_5678, "freq no strobe");
      $display("test freq done");
    end
  endtask
  task automatic t_phase;
    begin
      wr(`OFS_PHASE_HOLD, 32'hffff_fe5a);
      rd(`OFS_PHASE_HOLD, 32'h0000_025a, "phase holding");
      wr(`OFS_PHASE_STROBE, 32'h0);
      tick(1'b1);
      chk("phase after tick", active_phase_q, 32'h0000_025a);
      $display("test phase done");
    end
  endtask
  task automatic t_cfg;
    logic [3:0] c;
    logic [7:0] taps;
    begin
      for (int i = 0; i < 16; i++) begin
        c = i[3:0];
        taps = {c, 4'hf};
        wr(`OFS_HB_FIR_CONFIG, {12'h000, 5'b10110, c, c[0], 1'b0, c[1], taps});
        repeat (2) @(posedge sys_clk);
        chk("cfg fields", {halfband_stage_en_q, fir_decimation_q, fir_dual_real_q, fir_asymmetric_q, fir_taps_q},
          {5'b10110, (c == 4'h0) ? 5'h10 : {1'b0, c}, c[0], c[1], taps});
      end
      wr(`OFS_HB_FIR_CONFIG, 32'hffff_ffff);
      repeat (2) @(posedge sys_clk);
      chk("bypass stages", {halfband_bypass_q, halfband_stage_en_q}, 32'h20);
      rd(`OFS_HB_FIR_CONFIG, `CFG_WRITE_MASK, "cfg readback");
      $display("test config done");
    end
  endtask
  task automatic t_sync;
    begin
      wr(`OFS_HB_FIR_CONFIG, 32'h0010_0001);
      filter_sync_input <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("sync ignored", filter_ctrl_reset_q, 32'h0);
      filter_sync_input <= 1'b0;
      wr(`OFS_HB_FIR_CONFIG, 32'h0030_0001);
      filter_sync_input <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("sync resets", filter_ctrl_reset_q, 32'h1);
      filter_sync_input <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("sync released", filter_ctrl_reset_q, 32'h0);
      $display("test sync done");
    end
  endtask
  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Whole run is well under a thousand cycles; the limit leaves ample room
  initial begin
    #(20 * 10000);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_freq;
    t_phase;
    t_cfg;
    t_sync;
    give_verdict;
  end
endmodule // filter_config_and_nco_strobes_tb
